// >>> logic/bcce_core.sv
`timescale 1ns/1ps
// Functional notes
// - Branch-on-zero jumps to PC+2+2n when zero flag set; flags untouched.
// - Taken branch adds one no-operation cycle; untaken branch only steps PC by two.
// - Call pushes PC+4 onto return stack, loads literal into PC bits 20:1.
// - Fast-save bit copies working, flags and bank registers into shadows.
// - Call is two words, 1110110s then 1111, two cycles.
// - Clear-register writes zero to operand and sets zero flag.
// - Access bit low selects direct bank; high uses bank-select register.
// - Extended set with access low and operand up to 95 uses indexed offset.
// - Watchdog clear resets counter and postscaler, sets timeout and powerdown bits.
// - Complement inverts operand, destination bit picks working register or operand.
// - Compare-equal skips next instruction when operand equals working register.
// - Compare-greater skips when operand exceeds working register, unsigned.
// - Compare-less skips when operand is below working register, unsigned.
// - Skipped word runs as no-operation; a two-word victim costs one more cycle.
`include "bcce_regs.svh"

module bcce_core
    import bcce_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic wdt_clear,
    output logic [11:0] data_addr
);

    bcce_state_s s_q;
    bcce_state_s s_d;
    logic [11:0] eff;
    logic [7:0] opnd;
    logic [7:0] res;
    logic busy;

    // Effective data address from the access bit, operand and bank state.
    function automatic logic [11:0] bcce_eff_addr(input logic a, input logic [7:0] f, input logic [7:0] bank,
                                                  input logic ext, input logic [11:0] base);
        logic [11:0] r;
        r = {bank[3:0], f};
        if (!a && ext && f <= `BCCE_LITERAL_LIMIT) begin
            r = 12'(base + {4'h0, f});
        end else if (!a) begin
            r = (f <= `BCCE_LITERAL_LIMIT) ? {4'h0, f} : {`BCCE_ACCESS_HIGH_BANK, f};
        end
        return r;
    endfunction : bcce_eff_addr

    // Words that carry a second operand word and so cost two cycles when skipped.
    function automatic logic bcce_two_word(input logic [15:0] op);
        return op[15:12] == 4'hC || op[15:9] == 7'b1110110 || op[15:8] == 8'hEE || op[15:8] == 8'hEF;
    endfunction : bcce_two_word

    // Only the low four address bits index storage; the full address goes out on data_addr.
    assign busy = s_q.st != BCCE_IDLE;
    assign eff = bcce_eff_addr(s_q.ir[8], s_q.ir[7:0], s_q.bank_select_register, s_q.ext_en, s_q.base);
    assign opnd = s_q.mem[eff[3:0]];
    assign res = ~opnd;

    // An instruction write waits while the previous one still runs, which paces software.
    assign hreadyout = !(s_q.ahb_act && s_q.ahb_wr && s_q.ahb_addr == `BCCE_OFS_INSTR && busy);
    assign hrdata = s_q.rdata;
    assign hresp = 1'b0;
    assign wdt_clear = s_q.wdt_clr;
    assign data_addr = eff;

    // Bus slave, instruction sequencer and execute stage in one next-state process.
    always_comb begin
        s_d = s_q;
        s_d.wdt_clr = 1'b0;

        // Data phase of a write; execution below overrides software on a same-cycle clash.
        if (s_q.ahb_act && s_q.ahb_wr && hreadyout) begin
            if (s_q.ahb_addr == `BCCE_OFS_INSTR) begin
                s_d.ir = hwdata[15:0];
                s_d.st = BCCE_EXEC;
                s_d.q = 2'h0;
            end else if (s_q.ahb_addr == `BCCE_OFS_WORKING_REG_ALIAS) begin
                s_d.w = hwdata[7:0];
            end else if (s_q.ahb_addr == `BCCE_OFS_FLAGS) begin
                s_d.flags = {3'h0, hwdata[4:0]};
            end else if (s_q.ahb_addr == `BCCE_OFS_BANK) begin
                s_d.bank_select_register = hwdata[7:0];
            end else if (s_q.ahb_addr == `BCCE_OFS_PC) begin
                s_d.pc = {hwdata[20:1], 1'b0};
            end else if (s_q.ahb_addr == `BCCE_OFS_CTRL) begin
                s_d.ext_en = hwdata[`BCCE_CTRL_EXT];
                s_d.base = hwdata[`BCCE_CTRL_BASE_LSB +: 12];
            end else if (s_q.ahb_addr == `BCCE_OFS_STAT) begin
                s_d.to_bit = hwdata[`BCCE_STAT_TO];
                s_d.pd_bit = hwdata[`BCCE_STAT_PD];
            end else if (s_q.ahb_addr >= `BCCE_OFS_MEM_LO && s_q.ahb_addr <= `BCCE_OFS_MEM_HI) begin
                s_d.mem[s_q.ahb_addr[5:2]] = hwdata[7:0];
            end
        end

        // Address phase; read data is captured now so the data phase has no wait state.
        if (hready) begin
            s_d.ahb_act = hsel && htrans[1];
            s_d.ahb_wr = hwrite;
            s_d.ahb_addr = {haddr[7:2], 2'h0};
            s_d.rdata = 32'h0000_0000;
            if (hsel && htrans[1] && !hwrite) begin
                if (haddr[7:2] == `BCCE_OFS_INSTR >> 2) begin
                    s_d.rdata = {16'h0000, s_q.ir};
                end else if (haddr[7:2] == `BCCE_OFS_WORKING_REG_ALIAS >> 2) begin
                    s_d.rdata = {24'h000000, s_q.w};
                end else if (haddr[7:2] == `BCCE_OFS_FLAGS >> 2) begin
                    s_d.rdata = {24'h000000, s_q.flags};
                end else if (haddr[7:2] == `BCCE_OFS_BANK >> 2) begin
                    s_d.rdata = {24'h000000, s_q.bank_select_register};
                end else if (haddr[7:2] == `BCCE_OFS_PC >> 2) begin
                    s_d.rdata = {11'h000, s_q.pc};
                end else if (haddr[7:2] == `BCCE_OFS_STACK >> 2) begin
                    s_d.rdata = {11'h000, s_q.return_stack_top};
                end else if (haddr[7:2] == `BCCE_OFS_SHADOW >> 2) begin
                    s_d.rdata = {8'h00, s_q.bsr_s, s_q.flags_s, s_q.ws};
                end else if (haddr[7:2] == `BCCE_OFS_CTRL >> 2) begin
                    s_d.rdata = {4'h0, s_q.base, 15'h0000, s_q.ext_en};
                end else if (haddr[7:2] == `BCCE_OFS_STAT >> 2) begin
                    s_d.rdata = {26'h0000000, s_q.pd_bit, s_q.to_bit, s_q.swallow, s_q.call_pend, s_q.skip, busy};
                end else if (haddr[7:0] >= `BCCE_OFS_MEM_LO && haddr[7:0] <= `BCCE_OFS_MEM_HI) begin
                    s_d.rdata = {24'h000000, s_q.mem[haddr[5:2]]};
                end
            end
        end

        // Each instruction cycle is four clocks, one per quarter; effects land in the last.
        case (s_q.st)
            BCCE_IDLE: begin
                s_d.q = s_d.q;
            end
            BCCE_EXEC: begin
                s_d.q = 2'(s_q.q + 2'h1);
                if (s_q.q == `BCCE_Q_LAST) begin
                    s_d.st = BCCE_IDLE;
                    s_d.pc = 21'(s_q.pc + 21'h2);
                    if (s_q.swallow) begin
                        s_d.swallow = 1'b0;
                    end else if (s_q.skip) begin
                        s_d.skip = 1'b0;
                        s_d.swallow = bcce_two_word(s_q.ir);
                    end else if (s_q.call_pend) begin
                        s_d.call_pend = 1'b0;
                        if (s_q.ir[15:12] == 4'hF) begin
                            s_d.return_stack_top = 21'(s_q.pc + 21'h2);
                            s_d.pc = {s_q.ir[11:0], s_q.call_klo, 1'b0};
                            if (s_q.call_s) begin
                                s_d.ws = s_q.w;
                                s_d.flags_s = s_q.flags;
                                s_d.bsr_s = s_q.bank_select_register;
                            end
                        end
                    end else if (s_q.ir[15:8] == 8'hE0) begin
                        if (s_q.flags[`BCCE_FLAG_Z]) begin
                            s_d.pc = 21'(s_q.pc + 21'h2 + {{12{s_q.ir[7]}}, s_q.ir[7:0], 1'b0});
                            s_d.st = BCCE_NOP;
                            s_d.nops = 2'h1;
                        end
                    end else if (s_q.ir[15:9] == 7'b1110110) begin
                        s_d.call_pend = 1'b1;
                        s_d.call_s = s_q.ir[8];
                        s_d.call_klo = s_q.ir[7:0];
                    end else if (s_q.ir[15:9] == 7'b0110101) begin
                        s_d.mem[eff[3:0]] = 8'h00;
                        s_d.flags[`BCCE_FLAG_Z] = 1'b1;
                    end else if (s_q.ir == 16'h0004) begin
                        s_d.wdt_clr = 1'b1;
                        s_d.to_bit = 1'b1;
                        s_d.pd_bit = 1'b1;
                    end else if (s_q.ir[15:10] == 6'b000111) begin
                        if (s_q.ir[9]) begin
                            s_d.mem[eff[3:0]] = res;
                        end else begin
                            s_d.w = res;
                        end
                        s_d.flags[`BCCE_FLAG_Z] = res == 8'h00;
                        s_d.flags[`BCCE_FLAG_N] = res[7];
                    end else if (s_q.ir[15:9] == 7'b0110001) begin
                        s_d.skip = opnd == s_q.w;
                    end else if (s_q.ir[15:9] == 7'b0110010) begin
                        s_d.skip = opnd > s_q.w;
                    end else if (s_q.ir[15:9] == 7'b0110000) begin
                        s_d.skip = opnd < s_q.w;
                    end
                end
            end
            BCCE_NOP: begin
                s_d.q = 2'(s_q.q + 2'h1);
                if (s_q.q == `BCCE_Q_LAST) begin
                    s_d.nops = 2'(s_q.nops - 2'h1);
                    if (s_q.nops == 2'h1) begin
                        s_d.st = BCCE_IDLE;
                    end
                end
            end
            default: begin
                s_d.st = BCCE_IDLE;
            end
        endcase
    end

    // Whole state registered at once; timeout and powerdown bits come up set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.st <= BCCE_IDLE;
            s_q.to_bit <= 1'b1;
            s_q.pd_bit <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : bcce_core

// >>> logic/bcce_regs.svh
`ifndef BCCE_REGS_SVH
`define BCCE_REGS_SVH

// Register byte offsets on the bus.
`define BCCE_OFS_INSTR 8'h00
`define BCCE_OFS_WORKING_REG_ALIAS 8'h04
`define BCCE_OFS_FLAGS 8'h08
`define BCCE_OFS_BANK 8'h0C
`define BCCE_OFS_PC 8'h10
`define BCCE_OFS_STACK 8'h14
`define BCCE_OFS_SHADOW 8'h18
`define BCCE_OFS_CTRL 8'h1C
`define BCCE_OFS_STAT 8'h20
`define BCCE_OFS_MEM_LO 8'h40
`define BCCE_OFS_MEM_HI 8'h7C

// Flag register bit positions.
`define BCCE_FLAG_C 0
`define BCCE_FLAG_DC 1
`define BCCE_FLAG_Z 2
`define BCCE_FLAG_OV 3
`define BCCE_FLAG_N 4

// Status register bit positions.
`define BCCE_STAT_BUSY 0
`define BCCE_STAT_SKIP 1
`define BCCE_STAT_CALL 2
`define BCCE_STAT_SWALLOW 3
`define BCCE_STAT_TO 4
`define BCCE_STAT_PD 5

// Control register bit positions.
`define BCCE_CTRL_EXT 0
`define BCCE_CTRL_BASE_LSB 16

// Timing and addressing constants.
`define BCCE_Q_LAST 2'h3
`define BCCE_LITERAL_LIMIT 8'h5F
`define BCCE_ACCESS_HIGH_BANK 4'hF

`endif

// >>> logic/bcce_pkg.sv
package bcce_pkg;

    typedef enum logic [1:0] {
        BCCE_IDLE,
        BCCE_EXEC,
        BCCE_NOP
    } bcce_state_e;

    typedef struct packed {
        bcce_state_e st;
        logic [1:0] q;
        logic [1:0] nops;
        logic [15:0] ir;
        logic [7:0] w;
        logic [7:0] flags;
        logic [7:0] bank_select_register;
        logic [20:0] pc;
        logic [20:0] return_stack_top;
        logic [7:0] ws;
        logic [7:0] flags_s;
        logic [7:0] bsr_s;
        logic ext_en;
        logic [11:0] base;
        logic skip;
        logic swallow;
        logic call_pend;
        logic call_s;
        logic [7:0] call_klo;
        logic to_bit;
        logic pd_bit;
        logic wdt_clr;
        logic [15:0][7:0] mem;
        logic ahb_act;
        logic ahb_wr;
        logic [7:0] ahb_addr;
        logic [31:0] rdata;
    } bcce_state_s;

endpackage : bcce_pkg

// >>> tb/bcce_core_chk.sv
`timescale 1ns/1ps
module bcce_core_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic wdt_clear
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic ph_q;
    logic [15:0] w0_q;
    logic [15:0] w1_q;
    logic [3:0] st_q;
    // Keep two words, since the word after the cause may land before the pulse shows.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 1'b0;
            w0_q <= 16'h0000;
            w1_q <= 16'h0000;
            st_q <= 4'h0;
        end else begin
            if (hreadyout) begin
                ph_q <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
            end
            if (ph_q && hreadyout) begin
                w0_q <= hwdata[15:0];
                w1_q <= w0_q;
            end
            st_q <= hreadyout ? 4'h0 : st_q + 4'h1;
        end
    end
    sequence s_acc; hready && hsel && htrans[1]; endsequence
    sequence s_rd(logic [7:0] lo, logic [7:0] hi); s_acc ##0 !hwrite && haddr[7:0] inside {[lo:hi]}; endsequence
    property p_okay; hresp == 1'b0; endproperty
    property p_pulse; wdt_clear |=> !wdt_clear; endproperty
    property p_wdt_cause; wdt_clear |-> (w0_q == 16'h0004 || w1_q == 16'h0004); endproperty
    property p_stall_bound; st_q <= 4'hA; endproperty
    property p_stall_cause; $fell(hreadyout) |-> $past(hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00); endproperty
    property p_fast; s_acc ##0 !(hwrite && haddr[7:0] == 8'h00) |=> hreadyout; endproperty
    property p_unmapped; s_rd(8'h24, 8'h3C) |=> hrdata == 32'h0; endproperty
    property p_pc_even; s_rd(8'h10, 8'h14) |=> hrdata[0] == 1'b0 && hrdata[31:21] == 11'h0; endproperty
    a_okay: assert property (p_okay) else $error("bus response was not okay");
    a_pulse: assert property (p_pulse) else $error("watchdog clear longer than one cycle");
    a_wdt_cause: assert property (p_wdt_cause) else $error("watchdog clear without its opcode");
    a_stall_bound: assert property (p_stall_bound) else $error("bus stall too long");
    a_stall_cause: assert property (p_stall_cause) else $error("stall without instruction write");
    a_fast: assert property (p_fast) else $error("register access was stalled");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_pc_even: assert property (p_pc_even) else $error("program counter odd or too wide");
endmodule : bcce_core_chk

bind bcce_core bcce_core_chk bcce_core_chk_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .wdt_clear);

// >>> tb/bcce_core_bench.sv
`timescale 1ns/1ps
module bcce_core_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, wdt_clear;
    logic [31:0] hrdata, v, sh_e;
    logic [11:0] data_addr, base_e;
    int bad_count = 0;
    int total_checks = 0;
    int pulses = 0;
    logic [7:0] mem_e [16];
    logic [7:0] cmp [3] = '{8'h60, 8'h62, 8'h64};
    logic [7:0] w_e, f, r, n;
    logic [20:0] pc_e, tos_e;
    logic ext_e, z_e, n_e, sk, a;
    // Clock and a count of watchdog clear pulses.
    always #50 hclk = ~hclk;
    always @(posedge hclk) if (wdt_clear === 1'b1) pulses <= pulses + 1;
    bcce_core bcce_core_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .wdt_clear, .data_addr);
    task automatic finish_test;
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Ready and read data are sampled at the falling edge, where they have settled.
    task automatic wt(output logic [31:0] d);
        logic rdy;
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            d = hrdata;
            @(posedge hclk);
        end while (rdy !== 1'b1);
    endtask : wt
    task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        logic [31:0] x;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, ad};
        wt(x);
        htrans <= 2'h0;
        hwdata <= wd;
        wt(rd);
    endtask : xfer
    task automatic rc(input string nm, input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
        xfer(1'b0, ad, 32'h0, v);
        chk(nm, e & m, v & m);
    endtask : rc
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d, v);
    endtask : wr
    // Each word moves the counter by two; polling busy keeps words apart.
    task automatic ins(input logic [15:0] op);
        wr(8'h00, {16'h0, op});
        pc_e = pc_e + 21'h2;
        do xfer(1'b0, 8'h20, 32'h0, v); while (v[0] !== 1'b0);
    endtask : ins
    task automatic setm(input logic [3:0] i, input logic [7:0] d);
        mem_e[i] = d;
        wr(8'h40 + {2'h0, i, 2'h0}, {24'h0, d});
    endtask : setm
    // Only the low nibble reaches the small data memory.
    function automatic logic [3:0] ix(input logic ab, input logic [7:0] fa);
        logic [11:0] e;
        e = (!ab && ext_e && fa <= 8'h5F) ? base_e + {4'h0, fa} : {ab ? bsr_e_lo() : {4{fa[7]}}, fa};
        return e[3:0];
    endfunction : ix
    function automatic logic [3:0] bsr_e_lo();
        return 4'h3;
    endfunction : bsr_e_lo
    // Main sequence: compares with skips, complement and branch, calls, watchdog.
    initial begin
        void'($urandom(32'hb45ce40c));
        pc_e = 21'h0;
        {z_e, n_e, ext_e, base_e, sh_e} = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rc("stat", 8'h20, 32'h30, 32'h3F);
        wr(8'h0C, 32'h3);
        w_e = 8'($urandom);
        wr(8'h04, {24'h0, w_e});
        for (int i = 0; i < 16; i++) setm(i[3:0], 8'($urandom));
        for (int k = 0; k < 24; k++) begin
            v = $urandom;
            {ext_e, base_e, a, f} = v[21:0];
            wr(8'h1C, {4'h0, base_e, 15'h0, ext_e});
            if (k % 4 == 0) setm(ix(a, f), w_e);
            sk = (k % 3 == 0) ? mem_e[ix(a, f)] < w_e : (k % 3 == 1) ? mem_e[ix(a, f)] == w_e : mem_e[ix(a, f)] > w_e;
            ins({cmp[k % 3][7:1], a, f});
            rc("skip", 8'h20, {30'h0, sk, 1'b0}, 32'h2);
            {a, f} = v[30:22];
            ins({7'h35, a, f});
            if (!sk) {mem_e[ix(a, f)], z_e} = 9'h001;
            rc("mem", 8'h40 + {2'h0, ix(a, f), 2'h0}, {24'h0, mem_e[ix(a, f)]}, 32'hFF);
            rc("flags", 8'h08, {27'h0, n_e, 1'b0, z_e, 2'h0}, 32'h1F);
            rc("pc", 8'h10, {11'h0, pc_e}, 32'h1FFFFF);
        end
        for (int j = 0; j < 4; j++) begin
            v = $urandom;
            f = v[7:0];
            setm(ix(1'b1, f), j < 2 ? 8'hFF : v[15:8]);
            r = ~mem_e[ix(1'b1, f)];
            ins({6'h07, j[0], 1'b1, f});
            if (j[0]) mem_e[ix(1'b1, f)] = r;
            else w_e = r;
            {z_e, n_e} = {r == 8'h0, r[7]};
            n = j == 0 ? 8'h80 : v[23:16];
            ins({8'hE0, n});
            if (z_e) pc_e = pc_e + {{12{n[7]}}, n, 1'b0};
            rc("pc", 8'h10, {11'h0, pc_e}, 32'h1FFFFF);
            rc("flags", 8'h08, {27'h0, n_e, 1'b0, z_e, 2'h0}, 32'h1F);
            rc("w", 8'h04, {24'h0, w_e}, 32'hFF);
            rc("mem", 8'h40 + {2'h0, ix(1'b1, f), 2'h0}, {24'h0, mem_e[ix(1'b1, f)]}, 32'hFF);
        end
        // Second word goes out while the first still runs, so the bus must stall.
        for (int s = 1; s >= 0; s--) begin
            v = $urandom;
            w_e = v[7:0];
            wr(8'h04, {24'h0, w_e});
            tos_e = pc_e + 21'h4;
            wr(8'h00, {16'h0, 7'h76, s[0], v[15:8]});
            ins({4'hF, v[31:20]});
            pc_e = {v[31:20], v[15:8], 1'b0};
            if (s == 1) sh_e = {8'h0, 8'h03, 3'h0, n_e, 1'b0, z_e, 2'h0, w_e};
            rc("stack", 8'h14, {11'h0, tos_e}, 32'h1FFFFF);
            rc("pc", 8'h10, {11'h0, pc_e}, 32'h1FFFFF);
            rc("shadow", 8'h18, sh_e, 32'hFFFFFF);
        end
        setm(4'h0, w_e);
        ins(16'h6330);
        ins(16'hEC11);
        ins(16'hF222);
        rc("stack", 8'h14, {11'h0, tos_e}, 32'h1FFFFF);
        rc("pc", 8'h10, {11'h0, pc_e}, 32'h1FFFFF);
        wr(8'h20, 32'h0);
        ins(16'h0004);
        rc("stat", 8'h20, 32'h30, 32'h30);
        chk("pulses", 32'h1, pulses);
        wr(8'h30, 32'hFFFFFFFF);
        rc("unmapped", 8'h30, 32'h0, 32'hFFFFFFFF);
        finish_test();
    end
    // A hang costs one mismatch and ends the run the normal way.
    initial begin
        #2000000;
        bad_count++;
        finish_test();
    end
endmodule : bcce_core_bench
